//--- hw/aps_consts.svh
// Named constants of the reset and power sequencer.
`ifndef APS_CONSTS_SVH
`define APS_CONSTS_SVH
`define APS_CLK_MHZ 50
`define APS_PLL_START_MS 10
`define APS_PLL_CNT_W 20
`define APS_I2C_DEV_ADDR 7'h18
`define APS_BYTE_BITS 4'h8
`define APS_REG_PWR 8'h00
`define APS_REG_STAT 8'h01
`define APS_REG_MSEL 8'h02
`define APS_REG_MADDR 8'h03
`define APS_REG_MDATH 8'h04
`define APS_REG_MDATL 8'h05
`define APS_PWR_W 5
`define APS_PWR_RST 5'h00
`define APS_PWR_PLL 0
`define APS_PWR_ADC_L 1
`define APS_PWR_ADC_R 2
`define APS_PWR_PROC 3
`define APS_PWR_BIAS 4
`define APS_MSEL_A8 4
`define APS_STAT_PLL_RDY 0
`define APS_STAT_CLK_ON 1
`define APS_MADDR_W 9
`define APS_MADDR_RST 9'h000
`define APS_INSTR_DEPTH 512
`define APS_COEF_DEPTH 128
`define APS_DATA_DEPTH 256
`define APS_WORD_W 16
`define APS_GAIN_SHIFT 15
`define APS_COEF_UNITY 16'h7FFF
`endif

//--- hw/aps_pkg.sv
// Types shared by the reset and power sequencer modules.
`default_nettype none
`include "aps_consts.svh"
package aps_pkg;
   typedef struct packed
   {
      logic valid;
      logic [`APS_WORD_W-1:0] left;
      logic [`APS_WORD_W-1:0] right;
   } aps_sample_t;

   typedef enum logic [6:0]
   {
      I2C_IDLE  = 7'h01,
      I2C_ADDR  = 7'h02,
      I2C_ACK_A = 7'h04,
      I2C_WRITE = 7'h08,
      I2C_ACK_W = 7'h10,
      I2C_READ  = 7'h20,
      I2C_ACK_R = 7'h40
   } aps_i2c_state_t;

   typedef enum logic [1:0]
   {
      APS_MEM_INSTR = 2'h0,
      APS_MEM_COEF  = 2'h1,
      APS_MEM_DATA  = 2'h2
   } aps_mem_sel_t;
endpackage : aps_pkg
`default_nettype wire

//--- hw/aps_i2c.sv
// Two-wire control bus slave with a register pointer.
`default_nettype none
`include "aps_consts.svh"
module aps_i2c
   import aps_pkg::*;
(
   // Clock, reset, clock enable
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   // Bus pins
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda_o,
   output logic o_sda_oe,
   // Register side
   input wire logic i_accept,
   input wire logic [7:0] i_rdata,
   output logic o_wr,
   output logic [7:0] o_ptr,
   output logic [7:0] o_wdata
);
   logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
   logic [7:0] shreg, tx;
   logic [3:0] bitcnt;
   logic rw, have_ptr, nack, sda_low;
   aps_i2c_state_t state;

   wire scl_rise = scl_s & ~scl_d;
   wire scl_fall = ~scl_s & scl_d;
   wire bus_start = scl_s & scl_d & sda_d & ~sda_s;
   wire bus_stop = scl_s & scl_d & ~sda_d & sda_s;
   wire byte_done = (bitcnt == `APS_BYTE_BITS);
   wire addr_hit = (shreg[7:1] == `APS_I2C_DEV_ADDR) & i_accept;

   assign o_sda_o = 1'b0;
   assign o_sda_oe = sda_low;

   // ****************************************************************
   // Bus state machine; rates up to fast mode are oversampled.
   // ****************************************************************
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         {scl_m, scl_s, scl_d, sda_m, sda_s, sda_d} <= 6'h3F;
         state <= I2C_IDLE;
         shreg <= 8'h00;
         tx <= 8'h00;
         bitcnt <= 4'h0;
         rw <= 1'b0;
         have_ptr <= 1'b0;
         nack <= 1'b0;
         sda_low <= 1'b0;
         o_wr <= 1'b0;
         o_ptr <= 8'h00;
         o_wdata <= 8'h00;
      end
      else if (i_ce)
      begin
         scl_m <= i_scl;
         scl_s <= scl_m;
         scl_d <= scl_s;
         sda_m <= i_sda;
         sda_s <= sda_m;
         sda_d <= sda_s;
         o_wr <= 1'b0;
         if (o_wr)
            o_ptr <= o_ptr + 8'h01;
         if (bus_start)
         begin
            state <= I2C_ADDR;
            bitcnt <= 4'h0;
            have_ptr <= 1'b0;
            sda_low <= 1'b0;
         end
         else if (bus_stop)
         begin
            state <= I2C_IDLE;
            sda_low <= 1'b0;
         end
         else if (scl_rise)
         begin
            if (state == I2C_ADDR || state == I2C_WRITE)
            begin
               shreg <= {shreg[6:0], sda_s};
               bitcnt <= bitcnt + 4'h1;
            end
            if (state == I2C_ACK_R)
               nack <= sda_s;
         end
         else if (scl_fall)
         begin
            unique case (state)
               I2C_IDLE: state <= I2C_IDLE;
               I2C_ADDR:
                  if (byte_done)
                  begin
                     state <= addr_hit ? I2C_ACK_A : I2C_IDLE;
                     rw <= shreg[0];
                     sda_low <= addr_hit;
                  end
               I2C_ACK_A, I2C_ACK_R:
                  if (state == I2C_ACK_R && nack)
                  begin
                     state <= I2C_IDLE;
                     sda_low <= 1'b0;
                  end
                  else if (rw)
                  begin
                     state <= I2C_READ;
                     tx <= i_rdata;
                     sda_low <= ~i_rdata[7];
                     bitcnt <= 4'h1;
                     o_ptr <= o_ptr + 8'h01;
                  end
                  else
                  begin
                     state <= I2C_WRITE;
                     sda_low <= 1'b0;
                     bitcnt <= 4'h0;
                  end
               I2C_WRITE:
                  if (byte_done)
                  begin
                     state <= I2C_ACK_W;
                     sda_low <= 1'b1;
                     have_ptr <= 1'b1;
                     if (have_ptr)
                     begin
                        o_wr <= 1'b1;
                        o_wdata <= shreg;
                     end
                     else
                        o_ptr <= shreg;
                  end
               I2C_ACK_W:
               begin
                  state <= I2C_WRITE;
                  sda_low <= 1'b0;
                  bitcnt <= 4'h0;
               end
               I2C_READ:
                  if (byte_done)
                  begin
                     state <= I2C_ACK_R;
                     sda_low <= 1'b0;
                  end
                  else
                  begin
                     tx <= {tx[6:0], 1'b0};
                     sda_low <= ~tx[6];
                     bitcnt <= bitcnt + 4'h1;
                  end
               default: state <= I2C_IDLE;
            endcase
         end
      end
   end

   // ****************************************************************
   // Checks.
   // ****************************************************************
   property p_drive_only_ack_or_read;
      @(posedge i_clk) disable iff (i_rst)
      o_sda_oe |-> (state inside {I2C_ACK_A, I2C_ACK_W, I2C_READ});
   endproperty
   a_drive_only_ack_or_read: assert property (p_drive_only_ack_or_read)
      else $error("Data line driven outside acknowledge or read.");
endmodule : aps_i2c
`default_nettype wire

//--- hw/aps_seq.sv
// Reset and power sequencer with processor memories and stream tap.
`default_nettype none
`include "aps_consts.svh"
module aps_seq
   import aps_pkg::*;
#(
   parameter int PLL_LOCK_CYCLES = `APS_PLL_START_MS * `APS_CLK_MHZ * 1000
)
(
   // Clock, reset, clock enable
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   // Hardware reset pin
   input wire logic i_hw_reset_n,
   // Control bus pins
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda_o,
   output logic o_sda_oe,
   // Power and clock control
   output logic [`APS_PWR_W-1:0] o_block_pwr,
   output logic o_pll_ready,
   output logic o_clk_en,
   // Sample stream
   input wire aps_sample_t i_adc,
   output aps_sample_t o_out,
   // Processor core fetch ports
   input wire logic [`APS_MADDR_W-1:0] i_core_pc,
   input wire logic [7:0] i_core_daddr,
   output logic [`APS_WORD_W-1:0] o_core_instr,
   output logic [`APS_WORD_W-1:0] o_core_data
);
   localparam logic [`APS_PLL_CNT_W-1:0] LOCK_LAST =
      `APS_PLL_CNT_W'(PLL_LOCK_CYCLES - 1);

   // Depth mask of the selected memory, used for wrap and checks.
   function automatic logic [`APS_MADDR_W-1:0] depth_mask(
      input logic [1:0] sel);
      depth_mask = (sel == APS_MEM_INSTR) ?
         `APS_MADDR_W'(`APS_INSTR_DEPTH - 1) :
         (sel == APS_MEM_COEF) ? `APS_MADDR_W'(`APS_COEF_DEPTH - 1) :
         `APS_MADDR_W'(`APS_DATA_DEPTH - 1);
   endfunction : depth_mask

   // Signed gain by a Q15 coefficient.
   function automatic logic [`APS_WORD_W-1:0] apply_gain(
      input logic [`APS_WORD_W-1:0] smp,
      input logic [`APS_WORD_W-1:0] coef);
      logic signed [2*`APS_WORD_W-1:0] prod;
      prod = $signed(smp) * $signed(coef);
      apply_gain = prod[`APS_GAIN_SHIFT +: `APS_WORD_W];
   endfunction : apply_gain

   logic rst_pin_m, rst_pin_s, reset_seen;
   logic [`APS_PWR_W-1:0] pwr;
   logic [1:0] msel;
   logic [`APS_MADDR_W-1:0] maddr;
   logic [7:0] dhi;
   logic [`APS_PLL_CNT_W-1:0] pll_cnt;
   logic pll_ready;
   logic i2c_wr;
   logic [7:0] i2c_ptr, i2c_wdata;
   logic [`APS_WORD_W-1:0] instr_mem [`APS_INSTR_DEPTH];
   logic [`APS_WORD_W-1:0] coef_mem [`APS_COEF_DEPTH];
   logic [`APS_WORD_W-1:0] data_mem [`APS_DATA_DEPTH];

   // ****************************************************************
   // Reset pin synchroniser and decode.
   // ****************************************************************
   wire hw_rst = ~rst_pin_s;
   wire ctl_rst = i_rst | hw_rst;
   wire wr_pwr = i2c_wr & (i2c_ptr == `APS_REG_PWR);
   wire wr_msel = i2c_wr & (i2c_ptr == `APS_REG_MSEL);
   wire wr_maddr = i2c_wr & (i2c_ptr == `APS_REG_MADDR);
   wire wr_dhi = i2c_wr & (i2c_ptr == `APS_REG_MDATH);
   wire wr_dlo = i2c_wr & (i2c_ptr == `APS_REG_MDATL);
   wire [`APS_WORD_W-1:0] mem_word =
      (msel == APS_MEM_INSTR) ? instr_mem[maddr] :
      (msel == APS_MEM_COEF) ? coef_mem[maddr[6:0]] :
      data_mem[maddr[7:0]];
   wire [7:0] stat_byte = {6'h00, o_clk_en, pll_ready};
   wire [7:0] rdata =
      (i2c_ptr == `APS_REG_PWR) ? {3'h0, pwr} :
      (i2c_ptr == `APS_REG_STAT) ? stat_byte :
      (i2c_ptr == `APS_REG_MSEL) ? {3'h0, maddr[8], 2'h0, msel} :
      (i2c_ptr == `APS_REG_MADDR) ? maddr[7:0] :
      (i2c_ptr == `APS_REG_MDATH) ? mem_word[15:8] :
      (i2c_ptr == `APS_REG_MDATL) ? mem_word[7:0] : 8'h00;
   wire [`APS_MADDR_W-1:0] maddr_inc = (maddr + `APS_MADDR_W'(1))
      & depth_mask(msel);
   wire proc_on = pwr[`APS_PWR_PROC] & pll_ready;

   assign o_block_pwr = pwr;
   assign o_pll_ready = pll_ready;
   assign o_clk_en = pll_ready & pwr[`APS_PWR_PLL];

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         rst_pin_m <= 1'b1;
         rst_pin_s <= 1'b1;
         reset_seen <= 1'b0;
      end
      else if (i_ce)
      begin
         rst_pin_m <= i_hw_reset_n;
         rst_pin_s <= rst_pin_m;
         if (hw_rst)
            reset_seen <= 1'b1;
      end
   end

   // ****************************************************************
   // Control bus slave.
   // ****************************************************************
   aps_i2c u_i2c (
      .i_clk(i_clk),
      .i_rst(ctl_rst),
      .i_ce(i_ce),
      .i_scl(i_scl),
      .i_sda(i_sda),
      .o_sda_o(o_sda_o),
      .o_sda_oe(o_sda_oe),
      .i_accept(reset_seen),
      .i_rdata(rdata),
      .o_wr(i2c_wr),
      .o_ptr(i2c_ptr),
      .o_wdata(i2c_wdata)
   );

   // ****************************************************************
   // Power, memory pointer and PLL start-up counter.
   // ****************************************************************
   always_ff @(posedge i_clk)
   begin
      if (ctl_rst)
      begin
         pwr <= `APS_PWR_RST;
         msel <= APS_MEM_INSTR;
         maddr <= `APS_MADDR_RST;
         dhi <= 8'h00;
      end
      else if (i_ce)
      begin
         if (wr_pwr)
            pwr <= i2c_wdata[`APS_PWR_W-1:0];
         if (wr_msel)
         begin
            msel <= i2c_wdata[1:0];
            maddr <= {i2c_wdata[`APS_MSEL_A8], maddr[7:0]}
               & depth_mask(i2c_wdata[1:0]);
         end
         else if (wr_maddr)
            maddr <= {maddr[8], i2c_wdata} & depth_mask(msel);
         else if (wr_dlo)
            maddr <= maddr_inc;
         if (wr_dhi)
            dhi <= i2c_wdata;
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (ctl_rst)
      begin
         pll_cnt <= '0;
         pll_ready <= 1'b0;
      end
      else if (i_ce)
      begin
         if (!pwr[`APS_PWR_PLL])
         begin
            pll_cnt <= '0;
            pll_ready <= 1'b0;
         end
         else if (!pll_ready)
         begin
            pll_cnt <= pll_cnt + `APS_PLL_CNT_W'(1);
            pll_ready <= (pll_cnt == LOCK_LAST);
         end
      end
   end

   // ****************************************************************
   // Processor memories and stream tap; contents survive any reset.
   // ****************************************************************
   always_ff @(posedge i_clk)
   begin
      if (i_ce && wr_dlo)
      begin
         if (msel == APS_MEM_INSTR)
            instr_mem[maddr] <= {dhi, i2c_wdata};
         else if (msel == APS_MEM_COEF)
            coef_mem[maddr[6:0]] <= {dhi, i2c_wdata};
         else
            data_mem[maddr[7:0]] <= {dhi, i2c_wdata};
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         o_out <= '0;
         o_core_instr <= '0;
         o_core_data <= '0;
      end
      else if (i_ce)
      begin
         o_core_instr <= instr_mem[i_core_pc];
         o_core_data <= data_mem[i_core_daddr];
         o_out.valid <= i_adc.valid;
         o_out.left <= proc_on ? apply_gain(i_adc.left, coef_mem[0])
            : i_adc.left;
         o_out.right <= proc_on ? apply_gain(i_adc.right, coef_mem[0])
            : i_adc.right;
      end
   end

   // ****************************************************************
   // Checks.
   // ****************************************************************
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   sequence s_pll_req;
      i_ce && !hw_rst && pwr[`APS_PWR_PLL] && !pll_ready;
   endsequence
   sequence s_pll_armed;
      s_pll_req ##1 (pll_cnt != '0);
   endsequence

   property p_no_ack_without_reset;
      !reset_seen |-> !o_sda_oe;
   endproperty
   a_no_ack_without_reset: assert property (p_no_ack_without_reset)
      else $error("Bus acknowledged before a hardware reset.");

   property p_ready_after_full_count;
      $rose(pll_ready) |-> $past(pll_cnt) == LOCK_LAST;
   endproperty
   a_ready_after_full_count: assert property (p_ready_after_full_count)
      else $error("PLL ready raised before the start-up count ended.");

   property p_count_runs;
      s_pll_armed |-> pll_cnt == $past(pll_cnt) + `APS_PLL_CNT_W'(1);
   endproperty
   a_count_runs: assert property (p_count_runs)
      else $error("PLL counter did not step while powered.");

   property p_clk_gated;
      o_clk_en |-> pll_cnt == LOCK_LAST + `APS_PLL_CNT_W'(1);
   endproperty
   a_clk_gated: assert property (p_clk_gated)
      else $error("Derived clocks enabled before PLL ready.");

   property p_pll_off_clears;
      i_ce && !pwr[`APS_PWR_PLL] |=> pll_cnt == '0 && !pll_ready;
   endproperty
   a_pll_off_clears: assert property (p_pll_off_clears)
      else $error("PLL power off did not clear the start-up count.");

   property p_reset_powers_down;
      hw_rst |=> o_block_pwr == `APS_PWR_RST && !pll_ready;
   endproperty
   a_reset_powers_down: assert property (p_reset_powers_down)
      else $error("A block stayed powered through reset.");

   property p_pwr_write;
      i_ce && wr_pwr && !hw_rst |=>
         o_block_pwr == $past(i2c_wdata[`APS_PWR_W-1:0]);
   endproperty
   a_pwr_write: assert property (p_pwr_write)
      else $error("Power bits did not take the written value.");

   property p_pwr_keeps_settings;
      i_ce && wr_pwr && !hw_rst |=> $stable(maddr) && $stable(msel);
   endproperty
   a_pwr_keeps_settings: assert property (p_pwr_keeps_settings)
      else $error("Power write disturbed other settings.");

   property p_addr_steps;
      i_ce && wr_dlo && !hw_rst |=> maddr == $past(maddr_inc);
   endproperty
   a_addr_steps: assert property (p_addr_steps)
      else $error("Memory pointer did not advance after a word write.");

   property p_addr_in_range;
      maddr <= depth_mask(msel);
   endproperty
   a_addr_in_range: assert property (p_addr_in_range)
      else $error("Memory pointer beyond the selected memory.");

   property p_bypass;
      i_ce && !proc_on |=> o_out.left == $past(i_adc.left)
         && o_out.valid == $past(i_adc.valid);
   endproperty
   a_bypass: assert property (p_bypass)
      else $error("Stream not passed through with processor off.");
endmodule : aps_seq
`default_nettype wire

//--- dv/aps_i2c_host.sv
// Bus host model that drives the two-wire control pins.
`default_nettype none
`include "aps_consts.svh"
module aps_i2c_host
(
   // Clock and wire level of the data line
   input wire logic i_clk,
   input wire logic i_sda,
   // Host pins, high means released to the pull-up
   output logic o_scl,
   output logic o_sda
);
   timeunit 1ns;
   timeprecision 1ns;
   // Half period of the bus clock in system clocks; 62 is fast mode.
   int half = 62;
   initial
   begin
      o_scl = 1'b1;
      o_sda = 1'b1;
   end
   // ******************************************************
   // Bus cycles, all driven just after a falling clock edge.
   // ******************************************************
   task automatic tick(input int n);
      repeat (n) @(negedge i_clk);
   endtask : tick

   task automatic start_cond();
      o_sda = 1'b1;
      tick(half);
      o_scl = 1'b1;
      tick(half);
      o_sda = 1'b0;
      tick(half);
      o_scl = 1'b0;
      tick(8);
   endtask : start_cond

   task automatic stop_cond();
      o_sda = 1'b0;
      tick(half);
      o_scl = 1'b1;
      tick(half);
      o_sda = 1'b1;
      tick(half);
   endtask : stop_cond

   // Data changes only while the clock line is low, after a hold gap.
   task automatic bit_io(input logic b, output logic r);
      o_sda = b;
      tick(half);
      o_scl = 1'b1;
      tick(half / 2);
      r = i_sda;
      tick(half - half / 2);
      o_scl = 1'b0;
      tick(8);
   endtask : bit_io

   task automatic put_byte(input logic [7:0] d, output logic ok);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_io(d[i], r);
      bit_io(1'b1, r);
      ok = !r;
   endtask : put_byte

   task automatic wr(input logic [7:0] ptr, input logic [7:0] d[$],
      output logic ok);
      logic a;
      start_cond();
      put_byte({`APS_I2C_DEV_ADDR, 1'b0}, ok);
      put_byte(ptr, a);
      ok &= a;
      foreach (d[i])
      begin
         put_byte(d[i], a);
         ok &= a;
      end
      stop_cond();
   endtask : wr

   // Sets the pointer, then reads one byte and ends it with a NACK.
   task automatic rd(input logic [7:0] ptr, output logic [7:0] d,
      output logic ok);
      logic a;
      logic [7:0] empty[$];
      wr(ptr, empty, ok);
      start_cond();
      put_byte({`APS_I2C_DEV_ADDR, 1'b1}, a);
      ok &= a;
      for (int i = 7; i >= 0; i--)
         bit_io(1'b1, d[i]);
      bit_io(1'b1, a);
      stop_cond();
   endtask : rd
endmodule : aps_i2c_host
`default_nettype wire

//--- dv/adc_reset_power_sequencing_tb.sv
// Self-checking bench for the reset and power sequencer.
`default_nettype none
`include "aps_consts.svh"
module adc_reset_power_sequencing_tb
   import aps_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int LOCK = 600;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   logic hw_n = 1'b1;
   logic scl, host_sda, sda, sda_o, sda_oe, pll_ready, clk_en, ok;
   logic pwr_q = 1'b0;
   logic ce;
   logic [`APS_PWR_W-1:0] pwr;
   aps_sample_t adc;
   aps_sample_t out;
   logic [`APS_MADDR_W-1:0] pc;
   logic [7:0] daddr;
   logic [7:0] rb;
   logic [`APS_WORD_W-1:0] instr, data;
   int err_count = 0;
   int comparisons = 0;
   int cyc = 0;
   int t_pwr = 0;

   always #10 i_clk = ~i_clk;
   // The data line is pulled up; either party may pull it low.
   assign sda = host_sda & (~sda_oe | sda_o);
   always @(posedge i_clk)
   begin
      cyc <= cyc + 1;
      pwr_q <= pwr[0];
      if (pwr[0] && !pwr_q)
         t_pwr <= cyc;
   end

   aps_seq #(.PLL_LOCK_CYCLES(LOCK)) DUT (.i_clk(i_clk), .i_rst(i_rst),
      .i_ce(ce), .i_hw_reset_n(hw_n), .i_scl(scl), .i_sda(sda),
      .o_sda_o(sda_o), .o_sda_oe(sda_oe), .o_block_pwr(pwr),
      .o_pll_ready(pll_ready), .o_clk_en(clk_en), .i_adc(adc),
      .o_out(out), .i_core_pc(pc), .i_core_daddr(daddr),
      .o_core_instr(instr), .o_core_data(data));
   aps_i2c_host HOST (.i_clk(i_clk), .i_sda(sda), .o_scl(scl),
      .o_sda(host_sda));

   // ******************************************************
   // Checks and scenarios.
   // ******************************************************
   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : tally_and_finish

   task automatic pin_reset();
      hw_n = 1'b0;
      HOST.tick(2);
      hw_n = 1'b1;
      HOST.tick(8);
   endtask : pin_reset

   task automatic t_no_pulse();
      HOST.wr(`APS_REG_PWR, {8'h01}, ok);
      chk(ok, 1'b0);
      chk(pwr, '0);
      $display("Test no_pulse done");
   endtask : t_no_pulse

   task automatic t_pwr_bits();
      logic [7:0] v;
      for (int k = 0; k < `APS_PWR_W; k++)
      begin
         v = 8'h01 << k;
         HOST.wr(`APS_REG_PWR, {v}, ok);
         chk(ok, 1'b1);
         chk(pwr, v[`APS_PWR_W-1:0]);
      end
      HOST.wr(`APS_REG_PWR, {8'h00}, ok);
      chk(pwr, '0);
      $display("Test pwr_bits done");
   endtask : t_pwr_bits

   task automatic t_pll();
      int n;
      HOST.wr(`APS_REG_PWR, {8'h09}, ok);
      chk({pll_ready, clk_en}, 2'b00);
      for (n = 0; n < 2000 && pll_ready !== 1'b1; n++)
         HOST.tick(1);
      chk(cyc - t_pwr >= LOCK - 1 && cyc - t_pwr <= LOCK + 2, 1'b1);
      chk({pll_ready, clk_en}, 2'b11);
      if (n == 2000)
      begin
         err_count++;
         tally_and_finish();
      end
      $display("Test pll done");
   endtask : t_pll

   task automatic t_load();
      HOST.wr(`APS_REG_MSEL, {8'h01, 8'h00, 8'h40, 8'h00}, ok);
      HOST.wr(`APS_REG_MSEL, {8'h10, 8'hFF, 8'hA5, 8'h5A}, ok);
      HOST.wr(`APS_REG_MDATH, {8'h3C, 8'hC3}, ok);
      HOST.wr(`APS_REG_MSEL, {8'h02, 8'hFF, 8'hBE, 8'hEF}, ok);
      pc = 9'h1FF;
      daddr = 8'hFF;
      HOST.tick(2);
      chk(instr, 16'hA55A);
      chk(data, 16'hBEEF);
      pc = 9'h000;
      adc = {1'b1, 16'h1234, 16'h0800};
      HOST.tick(2);
      chk(instr, 16'h3CC3);
      chk(out, {1'b1, 16'h091A, 16'h0400});
      $display("Test load done");
   endtask : t_load

   task automatic t_keep();
      HOST.wr(`APS_REG_PWR, {8'h00}, ok);
      chk({pwr, pll_ready, clk_en}, '0);
      HOST.tick(2);
      chk(out, adc);
      chk(instr, 16'h3CC3);
      HOST.half = 250;
      HOST.rd(`APS_REG_MSEL, rb, ok);
      chk({ok, rb}, {1'b1, 8'h02});
      HOST.half = 62;
      $display("Test keep done");
   endtask : t_keep

   // With the clock enable low, stream and fetch outputs must hold.
   task automatic t_freeze();
      ce = 1'b0;
      adc = {1'b0, 16'hAAAA, 16'h5555};
      pc = 9'h1FF;
      HOST.tick(3);
      chk(out, {1'b1, 16'h1234, 16'h0800});
      chk(instr, 16'h3CC3);
      chk(sda_o, 1'b0);
      ce = 1'b1;
      HOST.tick(2);
      chk(out, adc);
      chk(instr, 16'hA55A);
      pc = 9'h000;
      HOST.tick(2);
      $display("Test freeze done");
   endtask : t_freeze

   task automatic t_pin_again();
      HOST.wr(`APS_REG_PWR, {8'h1F}, ok);
      chk(pwr, 5'h1F);
      pin_reset();
      chk({pwr, pll_ready, clk_en}, '0);
      chk(instr, 16'h3CC3);
      $display("Test pin_again done");
   endtask : t_pin_again

   initial
   begin
      ce = 1'b1;
      adc = '0;
      pc = '0;
      daddr = '0;
      HOST.tick(6);
      i_rst = 1'b0;
      t_no_pulse();
      pin_reset();
      t_pwr_bits();
      t_pll();
      t_load();
      t_keep();
      t_freeze();
      t_pin_again();
      tally_and_finish();
   end
endmodule : adc_reset_power_sequencing_tb
`default_nettype wire
